// *** rtl/spme_params.svh ***
// constants for the serial programming mode entry block
// assumes inclusion by bare name from rtl/ files only
`ifndef SPME_PARAMS_SVH
`define SPME_PARAMS_SVH

`define SPME_KEY_BITS    32            // length of the entry key in bits
`define SPME_KEY_VALUE   32'h3c5a_a5c3 // key pattern, value is arbitrary
`define SPME_CNT_W       6             // width of the key bit counter
`define SPME_SYNC_RST    2'h0          // synchroniser reset value
`define SPME_SYNC_MSB    1             // index of synchroniser output stage

`endif

// *** rtl/spme_pkg.sv ***
// types for the serial programming mode entry block
// assumes nothing beyond a SystemVerilog compiler
package spme_pkg;

  // session state, one-hot
  typedef enum logic [2:0] {
    SPME_IDLE = 3'h1,  // normal run, no session
    SPME_HV   = 3'h2,  // session entered by high voltage
    SPME_LV   = 3'h4   // session entered by key
  } spme_state_e;

endpackage

// *** rtl/spme_key_shift.sv ***
// key receiver running on the programmer's serial clock
// assumes arm_i comes from the system clock domain; the serial clock
// may stop between frames, so nothing here relies on free-running edges
`timescale 1ns/1ps
`default_nettype none
`include "spme_params.svh"

module spme_key_shift #(
  parameter int                      KEY_BITS = `SPME_KEY_BITS,
  parameter logic [KEY_BITS-1:0]     KEY      = `SPME_KEY_VALUE
) (
  input  wire logic link_clk_i,   // programmer serial clock
  input  wire logic rst_n_i,      // async reset, active low
  input  wire logic arm_i,        // key search allowed, other domain
  input  wire logic data_i,       // serial data pin level
  output logic      key_done_o    // full key matched, level
);

  logic                  clr_n;         // reset or disarm, active low
  logic [1:0]            arm_sync_reg;  // two-stage synchroniser
  logic [KEY_BITS-1:0]   shift_reg;     // incoming key bits, msb first
  logic [`SPME_CNT_W-1:0] cnt_reg;      // bits received since arming

  // arm_i is a flop output on clk_i; its fall clears this side at once,
  // because the serial clock may already have stopped and a stale match
  // would otherwise let the next attempt in without a key
  assign clr_n = rst_n_i && arm_i;

  // release of the clear passes two link flops before bits are counted
  always_ff @(posedge link_clk_i or negedge clr_n) begin
    if (!clr_n) begin
      arm_sync_reg <= `SPME_SYNC_RST;
    end else begin
      arm_sync_reg <= {arm_sync_reg[0], 1'b1};
    end
  end

  // shift key bits on each rising serial clock edge while armed, until KEY_BITS bits are in
  always_ff @(posedge link_clk_i or negedge clr_n) begin
    if (!clr_n) begin
      shift_reg <= '0;
      cnt_reg   <= '0;
    end else if (!arm_sync_reg[`SPME_SYNC_MSB]) begin
      // disarmed: forget any partial key
      shift_reg <= '0;
      cnt_reg   <= '0;
    end else if (cnt_reg != KEY_BITS[`SPME_CNT_W-1:0]) begin
      shift_reg <= {shift_reg[KEY_BITS-2:0], data_i};
      cnt_reg   <= cnt_reg + `SPME_CNT_W'(1);
    end
  end

  // match only once all key bits are in; a wrong key stays refused
  // until the search is re-armed
  always_ff @(posedge link_clk_i or negedge clr_n) begin
    if (!clr_n) begin
      key_done_o <= 1'b0;
    end else if (!arm_sync_reg[`SPME_SYNC_MSB]) begin
      key_done_o <= 1'b0;
    end else begin
      key_done_o <= (cnt_reg == KEY_BITS[`SPME_CNT_W-1:0]) &&
                    (shift_reg == KEY);
    end
  end

endmodule
`default_nettype wire

// *** rtl/spme_top.sv ***
// serial programming mode entry and session control
// assumes pin levels arrive unsynchronised; configuration bits and the
// command engine's data requests are on clk_i
`timescale 1ns/1ps
`default_nettype none
`include "spme_params.svh"

module spme_top #(
  parameter int                  KEY_BITS = `SPME_KEY_BITS,
  parameter logic [KEY_BITS-1:0] KEY      = `SPME_KEY_VALUE
) (
  input  wire logic clk_i,                   // system clock, 125 MHz
  input  wire logic rst_n_i,                 // async reset, active low
  input  wire logic prog_serial_clock_i,     // serial clock pin
  input  wire logic prog_serial_data_i,      // serial data pin, input
  output logic      prog_serial_data_o,      // serial data pin, output
  output logic      prog_serial_data_oe_o,   // serial data pin enable
  input  wire logic master_clear_n_i,        // master clear pin level
  input  wire logic high_voltage_i,          // master clear at vpp level
  input  wire logic low_voltage_prog_enable_i, // config bit
  input  wire logic mc_reset_cfg_i,          // config reset enable bit
  input  wire logic rd_data_i,               // read-back bit to send
  input  wire logic rd_drive_i,              // engine wants to drive pin
  input  wire logic en_clear_req_i,          // engine asks to clear bit
  output logic      prog_mode_o,             // session active
  output logic      hv_session_o,            // session by high voltage
  output logic      lv_session_o,            // session by key
  output logic      mc_reset_en_o,           // master clear reset on
  output logic      en_clear_grant_o         // clear allowed, follows request in a high voltage session
);

  // pin synchronisers, stage 0 is read only by stage 1
  logic [1:0] mc_sync_reg;     // master clear level
  logic [1:0] hv_sync_reg;     // high voltage detect
  logic [1:0] sck_sync_reg;    // serial clock as a level
  logic [1:0] sdat_sync_reg;   // serial data as a level
  logic [1:0] key_sync_reg;    // key matched, from link domain
  logic       hv_prev_reg;     // last synchronised high voltage level

  spme_pkg::spme_state_e state_reg;   // session state
  spme_pkg::spme_state_e state_next;  // next session state
  logic                  arm_reg;     // key search allowed
  logic                  key_done;    // link domain match level

  logic mc_s;     // synchronised master clear level
  logic hv_s;     // synchronised high voltage
  logic pins_low; // clock and data both low

  assign mc_s     = mc_sync_reg[`SPME_SYNC_MSB];
  assign hv_s     = hv_sync_reg[`SPME_SYNC_MSB];
  assign pins_low = !sck_sync_reg[`SPME_SYNC_MSB] &&
                    !sdat_sync_reg[`SPME_SYNC_MSB];

  // two flops on every foreign level before any logic reads it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mc_sync_reg   <= `SPME_SYNC_RST;
      hv_sync_reg   <= `SPME_SYNC_RST;
      sck_sync_reg  <= `SPME_SYNC_RST;
      sdat_sync_reg <= `SPME_SYNC_RST;
      key_sync_reg  <= `SPME_SYNC_RST;
    end else begin
      mc_sync_reg   <= {mc_sync_reg[0], master_clear_n_i};
      hv_sync_reg   <= {hv_sync_reg[0], high_voltage_i};
      sck_sync_reg  <= {sck_sync_reg[0], prog_serial_clock_i};
      sdat_sync_reg <= {sdat_sync_reg[0], prog_serial_data_i};
      key_sync_reg  <= {key_sync_reg[0], key_done};
    end
  end

  // edge memory for the high voltage detect
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hv_prev_reg <= 1'b0;
    end else begin
      hv_prev_reg <= hv_s;
    end
  end

  // key receiver on the programmer's clock
  spme_key_shift #(
    .KEY_BITS (KEY_BITS),
    .KEY      (KEY)
  ) u_key (
    .link_clk_i (prog_serial_clock_i),
    .rst_n_i    (rst_n_i),
    .arm_i      (arm_reg),
    .data_i     (prog_serial_data_i),
    .key_done_o (key_done)
  );

  // arm the key search only with the enable bit set and master clear
  // low; dropping arm wipes a partial key in the link domain
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      arm_reg <= 1'b0;
    end else begin
      arm_reg <= low_voltage_prog_enable_i && !mc_s &&
                 (state_reg == spme_pkg::SPME_IDLE);
    end
  end

  // session state decision
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      spme_pkg::SPME_IDLE: begin
        // high voltage wins; it only counts on its rising edge with
        // clock and data already low
        if (hv_s && !hv_prev_reg && pins_low) begin
          state_next = spme_pkg::SPME_HV;
        end else if (arm_reg && !mc_s &&
                     key_sync_reg[`SPME_SYNC_MSB]) begin
          state_next = spme_pkg::SPME_LV;
        end
      end
      spme_pkg::SPME_HV: begin
        // ends when the programming voltage goes away
        if (!hv_s) begin
          state_next = spme_pkg::SPME_IDLE;
        end
      end
      spme_pkg::SPME_LV: begin
        // master clear released or enable bit gone ends the session
        if (mc_s || !low_voltage_prog_enable_i) begin
          state_next = spme_pkg::SPME_IDLE;
        end
      end
      default: begin
        state_next = spme_pkg::SPME_IDLE;
      end
    endcase
  end

  // session state register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= spme_pkg::SPME_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // session flags, registered from the next state
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prog_mode_o  <= 1'b0;
      hv_session_o <= 1'b0;
      lv_session_o <= 1'b0;
    end else begin
      prog_mode_o  <= (state_next != spme_pkg::SPME_IDLE);
      hv_session_o <= (state_next == spme_pkg::SPME_HV);
      lv_session_o <= (state_next == spme_pkg::SPME_LV);
    end
  end

  // data pin drive; the clock pin never has a driver
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prog_serial_data_o    <= 1'b0;
      prog_serial_data_oe_o <= 1'b0;
    end else begin
      prog_serial_data_o    <= rd_data_i;
      prog_serial_data_oe_o <= rd_drive_i && prog_mode_o;
    end
  end

  // reset enable forced while key entry is possible, so a key session
  // can always be left by raising master clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mc_reset_en_o <= 1'b1;
    end else begin
      mc_reset_en_o <= low_voltage_prog_enable_i ||
                       mc_reset_cfg_i;
    end
  end

  // clearing the enable bit is granted only in a high voltage session
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      en_clear_grant_o <= 1'b0;
    end else begin
      en_clear_grant_o <= en_clear_req_i &&
                          (state_reg == spme_pkg::SPME_HV);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_key_needs_enable: assert property (
    $rose(lv_session_o) |-> $past(low_voltage_prog_enable_i, 2))
    else $error("key session entered with enable bit clear");

  chk_key_needs_match: assert property (
    $rose(lv_session_o) |-> $past(key_sync_reg[`SPME_SYNC_MSB]))
    else $error("key session entered without a matched key");

  chk_key_ends_clear: assert property (
    (lv_session_o && mc_s) |=> !lv_session_o)
    else $error("key session survived master clear release");

  chk_hv_pins_low: assert property (
    $rose(hv_session_o) |->
      $past(pins_low) && $past(hv_s) && !$past(hv_s, 2))
    else $error("high voltage entry without clock and data low");

  chk_reset_forced: assert property (
    low_voltage_prog_enable_i |=> mc_reset_en_o)
    else $error("master clear reset not forced on");

  chk_clear_only_hv: assert property (
    en_clear_grant_o |-> $past(hv_session_o))
    else $error("enable clear granted outside high voltage session");

  chk_drive_in_mode: assert property (
    prog_serial_data_oe_o |-> $past(prog_mode_o))
    else $error("data pin driven outside a session");

  chk_mode_flags: assert property (
    prog_mode_o |-> (hv_session_o ^ lv_session_o))
    else $error("session flags disagree");

endmodule
`default_nettype wire

// *** bench/spme_prog_model.sv ***
// behavioural model of the external programmer at the pins
// assumes the bench resolves the data wire against the device's enable
`timescale 1ns/1ps
`default_nettype none

module spme_prog_model (
  output logic sclk_o,           // serial clock, still outside frames
  output logic sdat_o,           // data the programmer drives
  output logic master_clear_n_o, // master clear pin level
  output logic hv_o              // master clear at programming voltage
);
  // idle: clock stands low, master clear released high
  initial begin
    sclk_o           = 1'b0;
    sdat_o           = 1'b0;
    master_clear_n_o = 1'b1;
    hv_o             = 1'b0;
  end

  // one bit: data moves while clock low, 15 ns period
  task automatic tick(input logic b);
    sdat_o = b;
    #7.5 sclk_o = 1'b1;
    #7.5 sclk_o = 1'b0;
  endtask

  // pins set first, then high voltage raised
  task automatic hv_enter(input logic c, input logic d);
    sclk_o = c;
    sdat_o = d;
    #41.3 hv_o = 1'b1;
  endtask

  // master clear low; two pad edges fill the device's arm synchroniser
  // and the third edge already takes a key bit, so a third pad would
  // leave the last key bit unshifted once the count is full; one closing edge lets the match be taken
  task automatic send_key(input logic [31:0] k);
    master_clear_n_o = 1'b0;
    #41.3;
    repeat (2) tick(1'b0);
    for (int i = 31; i >= 0; i--) begin
      tick(k[i]);
    end
    tick(1'b0);
  endtask

  // end of session: everything back to idle
  task automatic leave();
    hv_o             = 1'b0;
    master_clear_n_o = 1'b1;
    sclk_o           = 1'b0;
    sdat_o           = 1'b0;
  endtask
endmodule

`default_nettype wire

// *** bench/serial_program_mode_entry_bench.sv ***
// self-checking bench for the programming mode entry block
// assumes the programmer model drives the pins; engine side driven here
`timescale 1ns/1ps
`default_nettype none

module serial_program_mode_entry_bench;
  localparam logic [31:0] KEY = 32'h9a61_07e4; // arbitrary key pattern

  // one entry attempt and the session it should give
  typedef struct packed {
    logic        lv_en, c, d, key;
    logic [31:0] k;
    logic        hv, lv;
  } spme_row_s;

  logic clk_i = 1'b0;       // system clock
  logic rst_n_i = 1'b0;     // reset, active low
  logic lv_en = 1'b0;       // low voltage enable config bit
  logic cfg = 1'b0;         // reset enable config bit
  logic rd_data = 1'b0;     // read-back bit
  logic rd_drive = 1'b0;    // engine drive request
  logic clr_req = 1'b0;     // clear request for enable bit
  logic sclk, sdat, mc_n, hv, dat_o, oe;
  logic prog, hvs, lvs, mc_en, grant;
  wire  pin_dat = oe ? dat_o : sdat; // device wins while it drives
  int   errors = 0;
  int   checks = 0;
  int   cycles = 0;
  spme_row_s r;
  spme_row_s rows [6] = '{
    '{1'b0, 1'b0, 1'b0, 1'b0, KEY, 1'b1, 1'b0},
    '{1'b0, 1'b1, 1'b0, 1'b0, KEY, 1'b0, 1'b0},
    '{1'b0, 1'b0, 1'b1, 1'b0, KEY, 1'b0, 1'b0},
    '{1'b1, 1'b0, 1'b0, 1'b1, KEY, 1'b0, 1'b1},
    '{1'b0, 1'b0, 1'b0, 1'b1, KEY, 1'b0, 1'b0},
    '{1'b1, 1'b0, 1'b0, 1'b1, KEY ^ 32'h0000_0001, 1'b0, 1'b0}
  };

  // 125 MHz system clock
  initial begin
    forever #4 clk_i = ~clk_i;
  end

  spme_prog_model pgm (
    .sclk_o           (sclk),
    .sdat_o           (sdat),
    .master_clear_n_o (mc_n),
    .hv_o             (hv)
  );

  spme_top #(.KEY_BITS(32), .KEY(KEY)) DUT (
    .clk_i                     (clk_i),
    .rst_n_i                   (rst_n_i),
    .prog_serial_clock_i       (sclk),
    .prog_serial_data_i        (pin_dat),
    .prog_serial_data_o        (dat_o),
    .prog_serial_data_oe_o     (oe),
    .master_clear_n_i          (mc_n),
    .high_voltage_i            (hv),
    .low_voltage_prog_enable_i (lv_en),
    .mc_reset_cfg_i            (cfg),
    .rd_data_i                 (rd_data),
    .rd_drive_i                (rd_drive),
    .en_clear_req_i            (clr_req),
    .prog_mode_o               (prog),
    .hv_session_o              (hvs),
    .lv_session_o              (lvs),
    .mc_reset_en_o             (mc_en),
    .en_clear_grant_o          (grant)
  );

  // compare and count, mismatch reported at once
  task automatic check(input logic [2:0] got, input logic [2:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // hang guard: whole run needs well under 3000 cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      conclude();
    end
  end

  initial begin
    repeat (5) @(negedge clk_i);
    check({prog, hvs, mc_en}, 3'h1);
    rst_n_i = 1'b1;
    repeat (3) @(negedge clk_i);
    // entry rows, each then exercised (rows 0 and 3 inside a session) and closed
    for (int i = 0; i < 6; i++) begin
      r = rows[i];
      lv_en = r.lv_en;
      if (r.key) pgm.send_key(r.k);
      else pgm.hv_enter(r.c, r.d);
      repeat (12) @(negedge clk_i);
      check({prog, hvs, lvs}, {r.hv | r.lv, r.hv, r.lv});
      check({2'h0, mc_en}, {2'h0, r.lv_en});
      clr_req = 1'b1;
      rd_drive = 1'b1;
      rd_data = 1'b1;
      repeat (2) @(negedge clk_i);
      check({grant, oe, dat_o}, {r.hv, r.hv | r.lv, 1'b1});
      clr_req = 1'b0;
      rd_drive = 1'b0;
      rd_data = 1'b0;
      pgm.leave();
      repeat (8) @(negedge clk_i);
      check({prog, oe, grant}, 3'h0);
      check({2'h0, dat_o}, 3'h0);
      $display("row %0d done", i);
    end
    // reset enable bit alone switches the function on; the enable bit
    // from the last row must go first or it keeps the function forced
    lv_en = 1'b0;
    cfg = 1'b1;
    repeat (2) @(negedge clk_i);
    check({2'h0, mc_en}, 3'h1);
    cfg = 1'b0;
    repeat (2) @(negedge clk_i);
    check({2'h0, mc_en}, 3'h0);
    $display("reset enable test done");
    // second reset in mid-session drops the session at once
    pgm.hv_enter(1'b0, 1'b0);
    repeat (12) @(negedge clk_i);
    check({prog, hvs, lvs}, 3'h6);
    rst_n_i = 1'b0;
    @(negedge clk_i);
    check({prog, hvs, mc_en}, 3'h1);
    pgm.leave();
    rst_n_i = 1'b1;
    repeat (6) @(negedge clk_i);
    check({prog, hvs, lvs}, 3'h0);
    $display("mid-run reset test done");
    conclude();
  end
endmodule

`default_nettype wire
